// ---- hdl/acf_cfg.svh ----
// Constants for the output/reset configuration and fault flag bank.
// Assumes inclusion by bare name from the bank module, its monitor and the bench.
`ifndef ACF_CFG_SVH
`define ACF_CFG_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define ACF_OFS_CFG      4'h0
`define ACF_OFS_FLAGS    4'h4
`define ACF_OFS_LANECTL  4'h8

// ------------------------------------------------------------
// Address codes carried in bits 15:12 (arbitrary values)
// ------------------------------------------------------------
`define ACF_CODE_CFG     4'h2
`define ACF_CODE_FLAGS   4'h3
`define ACF_CODE_POS     12

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ACF_LANE_POS     8
`define ACF_CMD_POS      0
`define ACF_WCHK_POS     9
`define ACF_SETUP_POS    8
`define ACF_DHI_POS      7
`define ACF_ALEN_POS     0

// ------------------------------------------------------------
// Reset values and command codes
// ------------------------------------------------------------
`define ACF_LANE_RST     2'h0
`define ACF_ALEN_RST     1'h0
`define ACF_FLAGS_RST    10'h000
`define ACF_CMD_SOFT     8'h3C
`define ACF_CMD_HARD     8'hFF

// ------------------------------------------------------------
// AXI responses
// ------------------------------------------------------------
`define ACF_RESP_OKAY    2'h0
`define ACF_RESP_DECERR  2'h3

`endif

// ---- hdl/acf_pkg.sv ----
// Types for the output/reset configuration and fault flag bank.
// Assumes acf_cfg.svh holds all numeric constants.
package acf_pkg;

    // --------------------------------------------------------
    // Lane modes and whole-module state
    // --------------------------------------------------------
    typedef enum logic [1:0] {
        ACF_LANE_TWO,
        ACF_LANE_ONE,
        ACF_LANE_FOUR,
        ACF_LANE_ONE_ALT
    } acf_lane_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_got;
        logic        w_got;
        logic [3:0]  waddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        acf_lane_t   lane;
        logic        alert_en;
        logic [9:0]  flags;
        logic [3:0]  lane_en;
        logic        b_alarm;
        logic        d_alarm;
        logic        alarm;
        logic        soft_pulse;
        logic        hard_pulse;
    } acf_state_t;

endpackage : acf_pkg

// ---- hdl/acf_bank.sv ----
// Output/reset configuration and sticky fault flag registers behind AXI4-Lite.
// Assumes event inputs come from logic on REF_CLK_I, so they are not synchronised.
`timescale 1ns/10ps

`include "acf_cfg.svh"

module acf_bank
    import acf_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input  wire logic              REF_CLK_I,
    input  wire logic              SYS_RST_I,
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
    input  wire logic              S_AXI_AWVALID_I,
    output logic                   S_AXI_AWREADY_O,
    input  wire logic [31:0]       S_AXI_WDATA_I,
    input  wire logic [3:0]        S_AXI_WSTRB_I,
    input  wire logic              S_AXI_WVALID_I,
    output logic                   S_AXI_WREADY_O,
    output logic [1:0]             S_AXI_BRESP_O,
    output logic                   S_AXI_BVALID_O,
    input  wire logic              S_AXI_BREADY_I,
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
    input  wire logic              S_AXI_ARVALID_I,
    output logic                   S_AXI_ARREADY_O,
    output logic [31:0]            S_AXI_RDATA_O,
    output logic [1:0]             S_AXI_RRESP_O,
    output logic                   S_AXI_RVALID_O,
    output logic                   S_AXI_RREADY_UNUSED_O,
    input  wire logic              S_AXI_RREADY_I,
    input  wire logic              WRITE_CHECK_FAIL_I,
    input  wire logic              SETUP_LOAD_FAIL_I,
    input  wire logic [7:0]        CHANNEL_LIMIT_I,
    output logic [3:0]             LANE_EN_O,
    output logic                   LANE_B_ALARM_O,
    output logic                   LANE_D_ALARM_O,
    output logic                   ALARM_O,
    output logic                   SOFT_RESET_O,
    output logic                   HARD_RESET_O
);

    // --------------------------------------------------------
    // Parameter check
    // --------------------------------------------------------
    if (ADDR_W < 4 || ADDR_W > 16) begin : g_bad_addr
        $error("ADDR_W must be between 4 and 16");
    end

    // --------------------------------------------------------
    // State
    // --------------------------------------------------------
    acf_state_t  st_reg;
    acf_state_t  st_next;
    logic [3:0]  aw_lo;
    logic [3:0]  ar_lo;
    logic        do_write;
    logic        do_read;
    logic [7:0]  cmd_byte;
    logic        soft_cmd;
    logic        hard_cmd;
    logic [9:0]  flag_set;
    logic [9:0]  flag_clr;
    logic [15:0] cfg_word;
    logic [15:0] flag_word;

    assign aw_lo = S_AXI_AWADDR_I[3:0];
    assign ar_lo = S_AXI_ARADDR_I[3:0];

    // --------------------------------------------------------
    // Next state
    // --------------------------------------------------------
    always_comb begin
        st_next    = st_reg;
        do_write   = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
        do_read    = S_AXI_ARVALID_I && st_reg.arready;
        cmd_byte   = st_reg.wdata[`ACF_CMD_POS +: 8];
        soft_cmd   = 1'b0;
        hard_cmd   = 1'b0;
        flag_clr   = 10'h000;
        st_next.soft_pulse = 1'b0;
        st_next.hard_pulse = 1'b0;

        cfg_word = {`ACF_CODE_CFG, 2'h0, st_reg.lane, 8'h00};
        flag_word = {`ACF_CODE_FLAGS, 2'h0, st_reg.flags};

        // Write address and data are taken independently
        if (S_AXI_AWVALID_I && st_reg.awready) begin
            st_next.aw_got  = 1'b1;
            st_next.waddr   = aw_lo;
            st_next.awready = 1'b0;
        end
        if (S_AXI_WVALID_I && st_reg.wready) begin
            st_next.w_got  = 1'b1;
            st_next.wdata  = S_AXI_WDATA_I;
            st_next.wstrb  = S_AXI_WSTRB_I;
            st_next.wready = 1'b0;
        end

        if (do_write) begin
            st_next.aw_got = 1'b0;
            st_next.w_got  = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp  = `ACF_RESP_OKAY;
            case (st_reg.waddr)
                `ACF_OFS_CFG: begin
                    if (st_reg.wstrb[1]) begin
                        st_next.lane = acf_lane_t'(st_reg.wdata[`ACF_LANE_POS +: 2]);
                    end
                    if (st_reg.wstrb[0]) begin
                        soft_cmd = (cmd_byte == `ACF_CMD_SOFT);
                        hard_cmd = (cmd_byte == `ACF_CMD_HARD);
                        // other codes fall through with no action
                    end
                end
                `ACF_OFS_FLAGS: begin
                    // Flags are read-only; write is accepted and dropped
                end
                `ACF_OFS_LANECTL: begin
                    if (st_reg.wstrb[0]) begin
                        st_next.alert_en = st_reg.wdata[`ACF_ALEN_POS];
                    end
                end
                default: begin
                    st_next.bresp = `ACF_RESP_DECERR;
                end
            endcase
        end

        if (st_reg.bvalid && S_AXI_BREADY_I) begin
            st_next.bvalid = 1'b0;
        end

        // Ready for a new write only once the previous one is answered
        st_next.awready = !st_next.aw_got && !st_next.bvalid;
        st_next.wready  = !st_next.w_got && !st_next.bvalid;

        // Read channel
        if (do_read) begin
            st_next.rvalid  = 1'b1;
            st_next.arready = 1'b0;
            st_next.rresp   = `ACF_RESP_OKAY;
            case (ar_lo)
                `ACF_OFS_CFG: begin
                    st_next.rdata = {16'h0000, cfg_word};
                end
                `ACF_OFS_FLAGS: begin
                    st_next.rdata = {16'h0000, flag_word};
                    flag_clr[`ACF_WCHK_POS] = 1'b1;
                    flag_clr[7:0]           = 8'hFF;
                    flag_clr[`ACF_SETUP_POS] = 1'b0;
                end
                `ACF_OFS_LANECTL: begin
                    st_next.rdata = {31'h0, st_reg.alert_en};
                end
                default: begin
                    st_next.rdata = 32'h0000_0000;
                    st_next.rresp = `ACF_RESP_DECERR;
                end
            endcase
        end else if (st_reg.rvalid && S_AXI_RREADY_I) begin
            st_next.rvalid  = 1'b0;
            st_next.arready = 1'b1;
        end

        if (soft_cmd) begin
            flag_clr[`ACF_WCHK_POS] = 1'b1;
            flag_clr[7:0]           = 8'hFF;
        end

        // hard reset restores defaults and clears setup bit
        if (hard_cmd) begin
            flag_clr         = 10'h3FF;
            st_next.lane     = acf_lane_t'(`ACF_LANE_RST);
            st_next.alert_en = `ACF_ALEN_RST;
        end

        flag_set                  = 10'h000;
        flag_set[`ACF_WCHK_POS]   = WRITE_CHECK_FAIL_I;
        flag_set[`ACF_SETUP_POS]  = SETUP_LOAD_FAIL_I;
        flag_set[7:0]             = CHANNEL_LIMIT_I;

        st_next.flags = (st_reg.flags & ~flag_clr) | flag_set;

        st_next.soft_pulse = soft_cmd;
        st_next.hard_pulse = hard_cmd;

        // Lane drivers follow the committed mode
        case (st_next.lane)
            ACF_LANE_TWO: begin
                st_next.lane_en = 4'h3;
            end
            ACF_LANE_FOUR: begin
                st_next.lane_en = 4'hF;
            end
            ACF_LANE_ONE, ACF_LANE_ONE_ALT: begin
                st_next.lane_en = 4'h1;
            end
            default: begin
                st_next.lane_en = 4'h1;
            end
        endcase

        // alarm on lane B only in mode 01
        st_next.b_alarm = (st_next.lane == ACF_LANE_ONE) && st_next.alert_en;
        // lane D pin is alarm unless four-lane mode
        st_next.d_alarm = (st_next.lane != ACF_LANE_FOUR);
        st_next.alarm   = |st_next.flags;
    end

    // --------------------------------------------------------
    // Registers
    // --------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            st_reg          <= '0;
            st_reg.awready  <= 1'b1;
            st_reg.wready   <= 1'b1;
            st_reg.arready  <= 1'b1;
            st_reg.lane     <= acf_lane_t'(`ACF_LANE_RST);
            st_reg.alert_en <= `ACF_ALEN_RST;
            st_reg.flags    <= `ACF_FLAGS_RST;
            st_reg.lane_en  <= 4'h3;
            st_reg.d_alarm  <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // --------------------------------------------------------
    // Outputs, all straight from st_reg except S_AXI_RREADY_UNUSED_O, tied to 0
    // --------------------------------------------------------
    assign S_AXI_AWREADY_O       = st_reg.awready;
    assign S_AXI_WREADY_O        = st_reg.wready;
    assign S_AXI_BVALID_O        = st_reg.bvalid;
    assign S_AXI_BRESP_O         = st_reg.bresp;
    assign S_AXI_ARREADY_O       = st_reg.arready;
    assign S_AXI_RVALID_O        = st_reg.rvalid;
    assign S_AXI_RDATA_O         = st_reg.rdata;
    assign S_AXI_RRESP_O         = st_reg.rresp;
    assign S_AXI_RREADY_UNUSED_O = 1'b0;
    assign LANE_EN_O             = st_reg.lane_en;
    assign LANE_B_ALARM_O        = st_reg.b_alarm;
    assign LANE_D_ALARM_O        = st_reg.d_alarm;
    assign ALARM_O               = st_reg.alarm;
    assign SOFT_RESET_O          = st_reg.soft_pulse;
    assign HARD_RESET_O          = st_reg.hard_pulse;

endmodule : acf_bank

// ---- testbench/acf_evt_src.sv ----
// Event source beside the bank: fault pulses and the setup load.
// Assumes the bench requests pulses and a hard reset restarts the load.
`timescale 1ns/10ps
module acf_evt_src #(
    parameter int LOAD_CYC = 4
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [9:0] req_i,
    input  wire logic       bad_i,
    input  wire logic       hard_i,
    output logic            wchk_o = 1'b0,
    output logic            setup_o = 1'b0,
    output logic [7:0]      lim_o = 8'h00
);
    logic [3:0] cnt_reg = 4'h0;
    always @(posedge clk_i) begin
        if (rst_i || hard_i) begin
            cnt_reg <= 4'(LOAD_CYC);
        end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
        end
        // load failure reported at load end
        setup_o <= bad_i && (cnt_reg == 4'h1);
        wchk_o <= req_i[9];
        lim_o  <= req_i[7:0];
    end
endmodule : acf_evt_src

// ---- testbench/acf_bank_monitor.sv ----
// Checker on the ports of the config and fault flag bank.
// Assumes no read is taken while a command write completes.
`timescale 1ns/10ps
`include "acf_cfg.svh"
module acf_bank_mon #(
    parameter int ADDR_W = 4
) (
    input wire logic              REF_CLK_I,
    input wire logic              SYS_RST_I,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic              S_AXI_ARVALID_I,
    input wire logic              S_AXI_ARREADY_O,
    input wire logic [31:0]       S_AXI_RDATA_O,
    input wire logic              S_AXI_RVALID_O,
    input wire logic              S_AXI_BVALID_O,
    input wire logic              WRITE_CHECK_FAIL_I,
    input wire logic              SETUP_LOAD_FAIL_I,
    input wire logic [7:0]        CHANNEL_LIMIT_I,
    input wire logic [3:0]        LANE_EN_O,
    input wire logic              LANE_B_ALARM_O,
    input wire logic              LANE_D_ALARM_O,
    input wire logic              ALARM_O,
    input wire logic              SOFT_RESET_O,
    input wire logic              HARD_RESET_O
);
    // ----------------------------------------
    // Flags that a read must still show
    // ----------------------------------------
    logic [ADDR_W-1:0] ra_reg;
    logic [1:0]        seen_reg;
    logic [1:0]        pend_reg;
    wire               take = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    wire               rd4  = S_AXI_RVALID_O && ra_reg == `ACF_OFS_FLAGS;
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            ra_reg   <= '0;
            seen_reg <= 2'h0;
            pend_reg <= 2'h0;
        end else begin
            if (take) begin
                ra_reg   <= S_AXI_ARADDR_I;
                pend_reg <= seen_reg;
            end
            seen_reg[1] <= SETUP_LOAD_FAIL_I || (seen_reg[1] && !HARD_RESET_O);
            seen_reg[0] <= CHANNEL_LIMIT_I[7] || (seen_reg[0] && !SOFT_RESET_O && !HARD_RESET_O
                           && !(take && S_AXI_ARADDR_I == `ACF_OFS_FLAGS));
        end
    end
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    a_lane_legal: assert property (LANE_EN_O inside {4'h3, 4'h1, 4'hF})
        else $error("lane enables off pattern");
    a_lane_d_pin: assert property (LANE_D_ALARM_O == (LANE_EN_O != 4'hF))
        else $error("lane D pin role wrong");
    a_lane_b_pin: assert property (LANE_B_ALARM_O |-> LANE_EN_O == 4'h1)
        else $error("lane B alarm outside mode 01");
    a_code_cfg: assert property (S_AXI_RVALID_O && ra_reg == `ACF_OFS_CFG |-> S_AXI_RDATA_O[15:12] == `ACF_CODE_CFG)
        else $error("config code wrong");
    a_code_flags: assert property (rd4 |-> S_AXI_RDATA_O[15:12] == `ACF_CODE_FLAGS)
        else $error("flag code wrong");
    a_cmd_write: assert property (SOFT_RESET_O || HARD_RESET_O |-> S_AXI_BVALID_O)
        else $error("reset pulse without write");
    a_cmd_single: assert property (SOFT_RESET_O || HARD_RESET_O |=> !(SOFT_RESET_O || HARD_RESET_O))
        else $error("reset pulse too long");
    a_hard_lanes: assert property (HARD_RESET_O |-> ##[0:2] (LANE_EN_O == 4'h3 && !LANE_B_ALARM_O))
        else $error("hard reset kept lane mode");
    a_setup_kept: assert property (rd4 && pend_reg[1] |-> S_AXI_RDATA_O[8])
        else $error("setup flag lost");
    a_dhi_kept: assert property (rd4 && pend_reg[0] |-> S_AXI_RDATA_O[7])
        else $error("channel D flag lost");
    a_wchk_alarm: assert property (WRITE_CHECK_FAIL_I |-> ##[1:2] ALARM_O)
        else $error("write check fault not flagged");
    c_soft: cover property (SOFT_RESET_O);
    c_hard: cover property (HARD_RESET_O);
    c_setup: cover property (rd4 && pend_reg[1]);
endmodule : acf_bank_mon

bind acf_bank acf_bank_mon #(.ADDR_W(ADDR_W)) u_acf_bank_mon (
    .REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
    .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
    .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_BVALID_O(S_AXI_BVALID_O), .WRITE_CHECK_FAIL_I(WRITE_CHECK_FAIL_I),
    .SETUP_LOAD_FAIL_I(SETUP_LOAD_FAIL_I), .CHANNEL_LIMIT_I(CHANNEL_LIMIT_I), .LANE_EN_O(LANE_EN_O),
    .LANE_B_ALARM_O(LANE_B_ALARM_O), .LANE_D_ALARM_O(LANE_D_ALARM_O), .ALARM_O(ALARM_O),
    .SOFT_RESET_O(SOFT_RESET_O), .HARD_RESET_O(HARD_RESET_O));

// ---- testbench/tb_top.sv ----
// Self-checking bench for the config and fault flag bank.
// Assumes an AXI4-Lite master here and the event source model beside.
`timescale 1ns/10ps
`include "acf_cfg.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; $display("BAD %0t %h vs %h", $time, g, e); end end
module tb_top;
    logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, bad = 1'b1;
    logic [3:0]  awa = 4'h0, ara = 4'h0, ws = 4'h0, ln, lanes [4] = '{4'h3, 4'h1, 4'hF, 4'h1};
    logic [31:0] wd = 32'h0, rdat;
    logic [9:0]  ev = 10'h0;
    logic [7:0]  lim;
    logic [1:0]  br, rr;
    logic        awr, wr, bv, arr, rv, bal, dal, al, sft, hrd, wck, stp;
    int          err_total = 0, checks = 0, n_soft = 0, n_hard = 0;
    always #4 clk = ~clk;
    always @(posedge clk) begin
        n_soft += (sft === 1'b1);
        n_hard += (hrd === 1'b1);
    end
    acf_bank u_acf_bank (.REF_CLK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
        .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr),
        .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
        .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv),
        .S_AXI_RREADY_UNUSED_O(), .S_AXI_RREADY_I(rry), .WRITE_CHECK_FAIL_I(wck), .SETUP_LOAD_FAIL_I(stp),
        .CHANNEL_LIMIT_I(lim), .LANE_EN_O(ln), .LANE_B_ALARM_O(bal), .LANE_D_ALARM_O(dal), .ALARM_O(al),
        .SOFT_RESET_O(sft), .HARD_RESET_O(hrd));
    acf_evt_src u_acf_evt_src (.clk_i(clk), .rst_i(rst), .req_i(ev), .bad_i(bad), .hard_i(hrd),
        .wchk_o(wck), .setup_o(stp), .lim_o(lim));
    // ----------------------------------------
    // Bus and event tasks
    // ----------------------------------------
    task automatic wc(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
        bit ad = 0, dd = 0;
        @(posedge clk);
        {awa, wd, ws, awv, wv, bry} <= {a, d, s, 3'b111};
        while (!(ad && dd)) begin
            @(posedge clk);
            ad |= awr;
            dd |= wr;
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end
        do @(posedge clk); while (bv !== 1'b1);
        bry <= 1'b0;
        `CHK(br, e)
        @(negedge clk);
    endtask : wc
    task automatic rc(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er = `ACF_RESP_OKAY);
        @(posedge clk);
        {ara, arv, rry} <= {a, 2'b11};
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        rry <= 1'b0;
        `CHK(rdat, e)
        `CHK(rr, er)
    endtask : rc
    task automatic pulse(input logic [9:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= 10'h0;
    endtask : pulse
    task automatic tally_and_finish();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        rc(`ACF_OFS_CFG, 32'h2000);
        rc(`ACF_OFS_FLAGS, 32'h3100);
        `CHK(ln, 4'h3)
        for (int m = 0; m < 4; m++) begin
            wc(`ACF_OFS_CFG, 32'(m) << 8, 4'h2, `ACF_RESP_OKAY);
            wc(`ACF_OFS_LANECTL, 32'h1, 4'h1, `ACF_RESP_OKAY);
            `CHK(ln, lanes[m])
            `CHK(dal, 1'(m != 2))
            `CHK(bal, 1'(m == 1))
            rc(`ACF_OFS_CFG, 32'h2000 | (32'(m) << 8));
        end
        wc(`ACF_OFS_CFG, 32'h200, 4'h2, `ACF_RESP_OKAY);
        pulse(10'h281);
        rc(`ACF_OFS_FLAGS, 32'h3381);
        rc(`ACF_OFS_FLAGS, 32'h3100);
        `CHK(al, 1'b1)
        pulse(10'h081);
        wc(`ACF_OFS_CFG, 32'h3C, 4'h1, `ACF_RESP_OKAY);
        `CHK(n_soft, 1)
        `CHK(ln, 4'hF)
        rc(`ACF_OFS_FLAGS, 32'h3100);
        wc(`ACF_OFS_CFG, 32'h55, 4'h1, `ACF_RESP_OKAY);
        `CHK(n_soft + n_hard, 1)
        bad <= 1'b0;
        wc(`ACF_OFS_CFG, 32'hFF, 4'h1, `ACF_RESP_OKAY);
        `CHK(n_hard, 1)
        repeat (10) @(posedge clk);
        rc(`ACF_OFS_FLAGS, 32'h3000);
        `CHK(al, 1'b0)
        wc(`ACF_OFS_CFG, 32'h100, 4'h2, `ACF_RESP_OKAY);
        `CHK(bal, 1'b0)
        wc(4'hC, 32'h200, 4'hF, `ACF_RESP_DECERR);
        rc(4'hC, 32'h0, `ACF_RESP_DECERR);
        tally_and_finish();
    end
    initial begin
        #100us;
        err_total++;
        tally_and_finish();
    end
endmodule : tb_top
